// ===== pkg/sicond_pkg.sv
// constants and types for the slot input conditioning block
package sicond_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          TICK_US       = 100;
  localparam int          TICK_CYC      = CLK_HZ / 1000000 * TICK_US;
  localparam logic [11:0] A_DIN         = 12'h000;
  localparam logic [11:0] A_VAL1        = 12'h040;
  localparam logic [11:0] A_VAL2        = 12'h042;
  localparam logic [11:0] A_STAT        = 12'h050;
  localparam logic [11:0] A_IRQ_STAT    = 12'h060;
  localparam logic [11:0] A_IRQ_MASK    = 12'h064;
  localparam logic [11:0] A_DEB         = 12'h800;
  localparam logic [11:0] A_FLT1        = 12'h840;
  localparam logic [11:0] A_LO1         = 12'h844;
  localparam logic [11:0] A_HI1         = 12'h846;
  localparam logic [11:0] A_FLT2        = 12'h848;
  localparam logic [11:0] A_LO2         = 12'h84C;
  localparam logic [11:0] A_HI2         = 12'h84E;
  localparam logic [11:0] A_MODE        = 12'h850;
  localparam logic [7:0]  DEB_MAX       = 8'hFA;
  localparam logic [15:0] LIM_HI_RST    = 16'h7FFF;
  localparam logic [15:0] LIM_LO_RST    = 16'h8001;
  localparam logic [7:0]  MODE_RST      = 8'h11;
  localparam logic [2:0]  M_OFF         = 3'h0;
  localparam logic [2:0]  M_VOLT        = 3'h1;
  localparam logic [2:0]  M_I020        = 3'h2;
  localparam logic [2:0]  M_I420        = 3'h3;
  localparam logic [2:0]  M_TEMP        = 3'h4;
  localparam logic [2:0]  M_RES         = 3'h5;
  localparam logic [1:0]  ST_OK         = 2'h0;
  localparam logic [1:0]  ST_LOW        = 2'h1;
  localparam logic [1:0]  ST_HIGH       = 2'h2;
  localparam logic [1:0]  ST_OPEN       = 2'h3;
  localparam logic [3:0]  IRQ_W         = 4'h3;
  localparam logic signed [17:0] RNG_ZERO    = 18'h00000;
  localparam logic signed [17:0] RNG_V_LO    = 18'h38000;
  localparam logic signed [17:0] RNG_HI      = 18'h07FFF;
  localparam logic signed [17:0] RNG_I420_LO = 18'h3E000;
  localparam logic signed [17:0] RNG_T_LO    = 18'h3F830;
  localparam logic signed [17:0] RNG_T_HI    = 18'h02134;
  localparam logic signed [17:0] RNG_R_HI    = 18'h09C40;
  typedef enum logic [2:0] {
    SIC_IDLE = 3'b001,
    SIC_CH1  = 3'b010,
    SIC_CH2  = 3'b100
  } sic_state_t;
endpackage

// ===== hw/sicond_top.sv
// digital debounce and analog conditioning for one input slot
//
// Decided for this implementation: the Avalon-MM register port.
module sicond_top
  import sicond_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [3:0]  DIN,
  input  wire logic [15:0] ADC1_DATA,
  input  wire logic        ADC1_OPEN,
  input  wire logic [15:0] ADC2_DATA,
  input  wire logic        ADC2_OPEN,
  input  wire logic [11:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             IRQ
);
  // tick counter, free running so bus traffic never stalls it
  logic [15:0] tick_cnt;
  logic        tick;
  assign tick = (tick_cnt == 16'(TICK_CYC - 1));
  always_ff @(posedge CLK) begin
    if (RESET || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // bus registers
  logic [7:0]  deb_set;
  logic [7:0]  flt_cfg [2];
  logic [15:0] lim_lo  [2];
  logic [15:0] lim_hi  [2];
  logic [7:0]  mode_reg;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic        ack;
  logic        wr;
  logic        cfg_wr;
  // writes land on the edge after the wait state, the one that ends the access
  assign wr = AVS_WRITE && ack;
  assign cfg_wr = wr && AVS_BYTEENABLE[0];
  // one wait cycle on every access
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack;
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ || AVS_WRITE) && !ack;
    end
  end

  // debounce setting
  always_ff @(posedge CLK) begin
    if (RESET) begin
      deb_set <= 8'h00;
    end else if (cfg_wr && AVS_ADDRESS == A_DEB) begin
      deb_set <= AVS_WRITEDATA[7:0];
    end
  end

  // filter configs, reserved bits forced to zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      flt_cfg[0] <= 8'h00;
      flt_cfg[1] <= 8'h00;
    end else if (cfg_wr) begin
      if (AVS_ADDRESS == A_FLT1) begin
        flt_cfg[0] <= AVS_WRITEDATA[7:0] & 8'h77;
      end
      if (AVS_ADDRESS == A_FLT2) begin
        flt_cfg[1] <= AVS_WRITEDATA[7:0] & 8'h77;
      end
    end
  end

  // limits act from the next update on, no shadow copy
  always_ff @(posedge CLK) begin
    if (RESET) begin
      lim_lo[0] <= LIM_LO_RST;
      lim_lo[1] <= LIM_LO_RST;
      lim_hi[0] <= LIM_HI_RST;
      lim_hi[1] <= LIM_HI_RST;
    end else if (cfg_wr) begin
      if (AVS_ADDRESS == A_LO1) begin
        lim_lo[0] <= AVS_WRITEDATA[15:0];
      end
      if (AVS_ADDRESS == A_HI1) begin
        lim_hi[0] <= AVS_WRITEDATA[15:0];
      end
      if (AVS_ADDRESS == A_LO2) begin
        lim_lo[1] <= AVS_WRITEDATA[15:0];
      end
      if (AVS_ADDRESS == A_HI2) begin
        lim_hi[1] <= AVS_WRITEDATA[15:0];
      end
    end
  end

  // channel type
  always_ff @(posedge CLK) begin
    if (RESET) begin
      mode_reg <= MODE_RST;
    end else if (cfg_wr && AVS_ADDRESS == A_MODE) begin
      mode_reg <= AVS_WRITEDATA[7:0] & 8'h37;
    end
  end

  // interrupt mask
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_mask <= 4'h0;
    end else if (cfg_wr && AVS_ADDRESS == A_IRQ_MASK) begin
      irq_mask <= AVS_WRITEDATA[3:0];
    end
  end

  // digital debounce
  // raw lags one tick, so a level shows two ticks after the pin with debounce 0 or 1, one tick per debounce count above that up to DEB_MAX
  logic [3:0] raw;
  logic [3:0] din_state;
  logic [7:0] deb_cnt [4];
  logic [7:0] deb_lim;
  assign deb_lim = (deb_set > DEB_MAX) ? DEB_MAX : deb_set;
  generate
    for (genvar g = 0; g < 4; g++) begin : g_deb
      always_ff @(posedge CLK) begin
        if (RESET) begin
          raw[g]       <= 1'b0;
          din_state[g] <= 1'b0;
          deb_cnt[g]   <= 8'h00;
        end else if (tick) begin
          raw[g] <= DIN[g];
          if (deb_lim == 8'h00 || raw[g] == din_state[g]) begin
            if (deb_lim == 8'h00) begin
              din_state[g] <= raw[g];
            end
            deb_cnt[g] <= 8'h00;
          end else if (deb_cnt[g] + 8'h01 >= deb_lim) begin
            din_state[g] <= raw[g];
            deb_cnt[g]   <= 8'h00;
          end else begin
            deb_cnt[g] <= deb_cnt[g] + 8'h01;
          end
        end
      end
    end
  endgenerate

  // analog update interval
  function automatic logic is_iv(input logic [2:0] m);
    is_iv = (m == M_VOLT) || (m == M_I020) || (m == M_I420);
  endfunction
  logic [2:0] m1;
  logic [2:0] m2;
  logic [2:0] upd_ticks;
  assign m1 = mode_reg[2:0];
  assign m2 = {1'b0, mode_reg[5:4]};
  always_comb begin
    if (m1 != M_OFF && !is_iv(m1) && is_iv(m2)) begin
      upd_ticks = 3'h4;
    end else if ((m1 != M_OFF) && (m2 != M_OFF)) begin
      upd_ticks = 3'h2;
    end else if (m1 == M_TEMP || m1 == M_RES) begin
      upd_ticks = 3'h2;
    end else begin
      upd_ticks = 3'h1;
    end
  end
  logic [2:0] upd_cnt;
  logic       upd;
  assign upd = tick && (upd_cnt + 3'h1 >= upd_ticks);
  always_ff @(posedge CLK) begin
    if (RESET || upd) begin
      upd_cnt <= 3'h0;
    end else if (tick) begin
      upd_cnt <= upd_cnt + 3'h1;
    end
  end

  // per-channel conditioning, 18-bit math keeps unsigned resistance
  // step table spelled out so each code reads against its limit
  function automatic logic [15:0] ramp_step(input logic [2:0] c);
    case (c)
      3'h1:    ramp_step = 16'h3FFF;
      3'h2:    ramp_step = 16'h1FFF;
      3'h3:    ramp_step = 16'h0FFF;
      3'h4:    ramp_step = 16'h07FF;
      3'h5:    ramp_step = 16'h03FF;
      3'h6:    ramp_step = 16'h01FF;
      3'h7:    ramp_step = 16'h00FF;
      default: ramp_step = 16'h0000;
    endcase
  endfunction
  // filter level as divisor, shared by the old and new terms
  function automatic logic signed [17:0] flt_div(input logic [2:0] l);
    case (l)
      3'h1:    flt_div = 18'h00002;
      3'h2:    flt_div = 18'h00004;
      3'h3:    flt_div = 18'h00008;
      3'h4:    flt_div = 18'h00010;
      3'h5:    flt_div = 18'h00020;
      3'h6:    flt_div = 18'h00040;
      3'h7:    flt_div = 18'h00080;
      default: flt_div = 18'h00001;
    endcase
  endfunction
  // value range allowed in each channel mode
  function automatic logic signed [17:0] rng_lo(input logic [2:0] m);
    case (m)
      M_VOLT:  rng_lo = RNG_V_LO;
      M_I020:  rng_lo = RNG_ZERO;
      M_I420:  rng_lo = RNG_I420_LO;
      M_TEMP:  rng_lo = RNG_T_LO;
      M_RES:   rng_lo = RNG_ZERO;
      default: rng_lo = RNG_ZERO;
    endcase
  endfunction
  function automatic logic signed [17:0] rng_hi(input logic [2:0] m);
    case (m)
      M_VOLT:  rng_hi = RNG_HI;
      M_I020:  rng_hi = RNG_HI;
      M_I420:  rng_hi = RNG_HI;
      M_TEMP:  rng_hi = RNG_T_HI;
      M_RES:   rng_hi = RNG_R_HI;
      default: rng_hi = RNG_ZERO;
    endcase
  endfunction
  function automatic logic signed [17:0] ext(input logic [15:0] v,
                                              input logic       u);
    ext = u ? {2'b00, v} : {{2{v[15]}}, v};
  endfunction
  logic        [15:0] value    [2];
  logic        [15:0] filt     [2];
  logic        [1:0]  stat     [2];
  logic        [15:0] adc      [2];
  logic               open_l   [2];
  logic        [2:0]  ch_mode  [2];
  assign adc[0]     = ADC1_DATA;
  assign adc[1]     = ADC2_DATA;
  assign open_l[0]  = ADC1_OPEN;
  assign open_l[1]  = ADC2_OPEN;
  assign ch_mode[0] = m1;
  assign ch_mode[1] = is_iv(m2) ? m2 : M_OFF;
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      logic               uns;
      logic [2:0]         lvl;
      logic [2:0]         rc;
      logic signed [17:0] x;
      logic signed [17:0] xr;
      logic signed [17:0] rlo;
      logic signed [17:0] rhi;
      logic signed [17:0] old;
      logic signed [17:0] d;
      logic signed [17:0] st;
      logic signed [17:0] r;
      logic signed [17:0] nf;
      logic signed [17:0] lo;
      logic signed [17:0] hi;
      logic signed [17:0] q1;
      logic signed [17:0] q2;
      assign uns = (ch_mode[c] == M_RES);
      assign lvl = flt_cfg[c][2:0];
      assign rc  = flt_cfg[c][6:4];
      assign xr  = ext(adc[c], uns);
      assign rlo = rng_lo(ch_mode[c]);
      assign rhi = rng_hi(ch_mode[c]);
      // out-of-range samples pinned before ramp and filter see them
      always_comb begin
        if (xr < rlo) begin
          x = rlo;
        end else if (xr > rhi) begin
          x = rhi;
        end else begin
          x = xr;
        end
      end
      assign old = ext(filt[c], uns);
      assign d   = x - old;
      assign st  = ext(ramp_step(rc), 1'b1);
      always_comb begin
        r = x;
        if (lvl != 3'h0 && rc != 3'h0) begin
          if (d > st) begin
            r = old + st;
          end else if (d < -st) begin
            r = old - st;
          end
        end
        // signed division truncates toward zero
        q1 = old / flt_div(lvl);
        q2 = r / flt_div(lvl);
        nf = (lvl == 3'h0) ? x : old - q1 + q2;
      end
      assign lo = ext(lim_lo[c], uns);
      assign hi = ext(lim_hi[c], uns);
      always_ff @(posedge CLK) begin
        if (RESET) begin
          filt[c]  <= 16'h0000;
          value[c] <= 16'h0000;
          stat[c]  <= ST_OK;
        end else if (upd) begin
          if (ch_mode[c] == M_OFF) begin
            filt[c]  <= 16'h0000;
            value[c] <= 16'h0000;
            stat[c]  <= ST_OK;
          end else begin
            filt[c] <= nf[15:0];
            if (open_l[c]) begin
              stat[c]  <= ST_OPEN;
              value[c] <= nf[15:0];
            end else if (nf < lo) begin
              stat[c]  <= ST_LOW;
              value[c] <= lim_lo[c];
            end else if (nf > hi) begin
              stat[c]  <= ST_HIGH;
              value[c] <= lim_hi[c];
            end else begin
              stat[c]  <= ST_OK;
              value[c] <= nf[15:0];
            end
          end
        end
      end
    end
  endgenerate

  // status-change events, set wins over write-one-to-clear
  logic [3:0] stat_now;
  logic [3:0] stat_prev;
  logic [3:0] ev;
  // channel 1 change lands in bit 0, channel 2 in bit 1
  assign stat_now = {stat[1], stat[0]};
  assign ev = {|(stat_now[3:2] ^ stat_prev[3:2]),
               |(stat_now[1:0] ^ stat_prev[1:0]), 2'b00};
  always_ff @(posedge CLK) begin
    if (RESET) begin
      stat_prev <= 4'h0;
      irq_stat  <= 4'h0;
    end else begin
      stat_prev <= stat_now;
      if (wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == A_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~AVS_WRITEDATA[3:0]) | (ev >> 2);
      end else begin
        irq_stat <= irq_stat | (ev >> 2);
      end
    end
  end
  assign IRQ = |(irq_stat & irq_mask & IRQ_W);

  // read mux, write-only config reads zero
  always_ff @(posedge CLK) begin
    if (RESET) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      // loaded once per read, the word stands until the next read
      case (AVS_ADDRESS)
        A_DIN:      AVS_READDATA <= {28'h0, din_state};
        A_VAL1:     AVS_READDATA <= {16'h0, value[0]};
        A_VAL2:     AVS_READDATA <= {16'h0, value[1]};
        A_STAT:     AVS_READDATA <= {28'h0, stat_now};
        A_IRQ_STAT: AVS_READDATA <= {28'h0, irq_stat};
        A_IRQ_MASK: AVS_READDATA <= {28'h0, irq_mask};
        default:    AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end
endmodule // sicond_top

// ===== bench/sicond_monitor.sv
// bus and interrupt checks on the slot conditioning top ports
module sicond_monitor
  import sicond_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic acc;
  logic rd_ok;
  assign acc = AVS_READ || AVS_WRITE;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  property p_wait_first; acc && !$past(acc) |-> AVS_WAITREQUEST; endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("new access not stalled");
  property p_wait_one; acc && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer late");
  property p_wait_idle; !acc |-> !AVS_WAITREQUEST; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("stall when idle");
  // readdata must not wander between accesses
  property p_rd_hold;
    !acc && !$past(acc) && !$past(RESET) |-> $stable(AVS_READDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
  property p_din_hi;
    rd_ok && AVS_ADDRESS == A_DIN |-> AVS_READDATA[7:4] == 4'h0;
  endproperty
  a_din_hi: assert property (p_din_hi) else $error("din upper bits set");
  property p_stat_hi;
    rd_ok && AVS_ADDRESS == A_STAT |-> AVS_READDATA[7:4] == 4'h0;
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("status nibble set");
  // config space is write only, holes read zero
  property p_cfg_zero; rd_ok && AVS_ADDRESS[11] |-> AVS_READDATA == 32'h0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("config readable");
  property p_mask_off;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == A_IRQ_MASK &&
      AVS_BYTEENABLE[0] && AVS_WRITEDATA[1:0] == 2'h0 |=> !IRQ;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq");
endmodule // sicond_monitor

bind sicond_top sicond_monitor u_sicond_monitor (.CLK(CLK), .RESET(RESET),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IRQ(IRQ));

// ===== bench/sicond_sensor.sv
// field sensor model driving the slot input terminals
module sicond_sensor (
  input  wire logic  clk,
  output logic [3:0]  din,
  output logic [15:0] adc1,
  output logic        open1,
  output logic [15:0] adc2,
  output logic        open2
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    din = 4'h0;
    adc1 = 16'h0000;
    open1 = 1'b0;
    adc2 = 16'h0000;
    open2 = 1'b0;
  end
  // levels change only just after an edge, like a real sampled source
  task automatic set_in(input logic [3:0] d, input logic [15:0] a1, a2,
                        input logic [1:0] op);
    @(posedge clk);
    din <= d;
    adc1 <= a1;
    adc2 <= a2;
    {open2, open1} <= op;
  endtask
endmodule // sicond_sensor

// ===== bench/sicond_top_test.sv
// self-checking bench for the slot input conditioning block
module sicond_top_test
  import sicond_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] din; logic [15:0] a1; logic [15:0] a2; logic [1:0] op;
    logic [15:0] v1; logic [15:0] v2; logic [3:0] st;
  } sic_row_t;
  logic        CLK = 0;
  logic        RESET = 1;
  logic [11:0] AVS_ADDRESS = 0;
  logic        AVS_READ = 0;
  logic        AVS_WRITE = 0;
  logic [31:0] AVS_WRITEDATA = 0;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA, rd;
  logic        AVS_WAITREQUEST, IRQ, ADC1_OPEN, ADC2_OPEN;
  logic [3:0]  DIN;
  logic [15:0] ADC1_DATA, ADC2_DATA;
  int          n_fail = 0;
  int          checked = 0;
  // lower clamp at 8001 and open line win over plain values
  sic_row_t    rows [3] = '{
    '{4'h1, 16'h1234, 16'hF000, 2'h0, 16'h1234, 16'hF000, 4'h0},
    '{4'h8, 16'h7FFF, 16'h8000, 2'h0, 16'h7FFF, 16'h8001, 4'h4},
    '{4'h6, 16'h0100, 16'h0000, 2'h1, 16'h0100, 16'h0000, 4'h3}};
  sicond_top u_sicond_top (.CLK(CLK), .RESET(RESET), .DIN(DIN),
    .ADC1_DATA(ADC1_DATA), .ADC1_OPEN(ADC1_OPEN), .ADC2_DATA(ADC2_DATA),
    .ADC2_OPEN(ADC2_OPEN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));
  sicond_sensor u_sicond_sensor (.clk(CLK), .din(DIN), .adc1(ADC1_DATA),
    .open1(ADC1_OPEN), .adc2(ADC2_DATA), .open2(ADC2_OPEN));
  always #4 CLK = ~CLK;
  task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge CLK);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    // waitrequest judged mid-cycle, the next rising edge ends the access
    do begin
      @(negedge CLK);
      done = (AVS_WAITREQUEST === 1'b0);
      n++;
      @(posedge CLK);
    end while (!done && n < 50);
    chk(done, 1);
    rd = AVS_READDATA;
    AVS_READ <= 0;
    AVS_WRITE <= 0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [15:0] e);
    bus(0, a, 0);
    chk(rd[15:0], e);
  endtask
  // poll until equal, or until changed when ne is set; bounded
  task automatic pw(input logic [11:0] a, input logic [15:0] v, input bit ne);
    int k;
    k = 0;
    do begin
      bus(0, a, 0);
      k++;
    end while (((rd[15:0] === v) == ne) && k < 20000);
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
    chk(IRQ, 0);
    bus(1, A_IRQ_MASK, 3);
    rc(12'hF00, 0);
    rc(A_FLT1, 0);
    foreach (rows[i]) begin
      u_sicond_sensor.set_in(rows[i].din, rows[i].a1, rows[i].a2, rows[i].op);
      pw(A_VAL2, rows[i].v2, 0);
      chk(rd[15:0], rows[i].v2);
      rc(A_VAL1, rows[i].v1);
      rc(A_STAT, rows[i].st);
      pw(A_DIN, rows[i].din, 0);
      chk(rd[15:0], rows[i].din);
    end
    chk(IRQ, 1);
    rc(A_IRQ_STAT, 16'h3);
    bus(1, A_IRQ_MASK, 0);
    bus(1, A_IRQ_STAT, 3);
    rc(A_IRQ_STAT, 0);
    bus(1, A_IRQ_MASK, 3);
    @(negedge CLK);
    chk(IRQ, 0);
    bus(1, A_HI1, 32'h1000);
    u_sicond_sensor.set_in(4'h6, 16'h1234, 16'h0, 2'h0);
    pw(A_VAL1, 16'h1000, 0);
    chk(rd[15:0], 16'h1000);
    rc(A_STAT, 16'h2);
    u_sicond_sensor.set_in(4'h6, 16'h1000, 16'h0, 2'h0);
    bus(1, A_HI1, 32'h7FFF);
    bus(1, A_MODE, 32'h01);
    // status back to ok means the filter state now holds 1000
    pw(A_STAT, 16'h0, 0);
    chk(rd[15:0], 16'h0);
    bus(1, A_FLT1, 32'h41);
    bus(1, A_DEB, 32'h3);
    // jump of 2000 is cut to 7FF, then halved into the old value
    u_sicond_sensor.set_in(4'h9, 16'h3000, 16'h0, 2'h0);
    pw(A_VAL1, 16'h1000, 1);
    chk(rd[15:0], 16'h13FF);
    rc(A_DIN, 16'h6);
    pw(A_DIN, 16'h9, 0);
    chk(rd[15:0], 16'h9);
    @(posedge CLK);
    RESET <= 1;
    repeat (4) @(posedge CLK);
    RESET <= 0;
    rc(A_VAL1, 16'h0);
    rc(A_STAT, 16'h0);
    rc(A_DIN, 16'h0);
    chk(IRQ, 0);
    close_out;
  end
  initial begin
    repeat (40 * TICK_CYC) @(posedge CLK);
    n_fail++;
    close_out;
  end
endmodule // sicond_top_test
